/* File: ues_consts.svh */
// Purpose: Constants for the host endpoint schedule block
// Assumes: Included by the package and the top module
// Notes:   Register indices scale by four to give AXI byte addresses
`ifndef UES_CONSTS_SVH
`define UES_CONSTS_SVH

// Endpoint slots; slot 0 carries no type or interval registers
`define UES_NEP            4

// Register indices
`define UES_IDX_RX_COUNT   32'h1344_0018
`define UES_IDX_TX_TYPE    32'h1344_001A
`define UES_IDX_TX_IVL     32'h1344_001B
`define UES_IDX_RX_TYPE    32'h1344_001C
`define UES_IDX_RX_IVL     32'h1344_001D
`define UES_IDX_EP_SEL     32'h1344_0030
`define UES_IDX_IRQ_STAT   32'h1344_0031
`define UES_IDX_IRQ_MASK   32'h1344_0032

// Protocol field codes
`define UES_PROTO_ILLEGAL  2'h0
`define UES_PROTO_ISO      2'h1
`define UES_PROTO_BULK     2'h2
`define UES_PROTO_INTR     2'h3

// Interval limits
`define UES_EXP_MAX        8'h10
`define UES_BULK_MIN       8'h02

// AXI responses
`define UES_RESP_OKAY      2'h0
`define UES_RESP_SLVERR    2'h2

// Reset values
`define UES_RST_COUNT      13'h0000
`define UES_RST_IVL        8'h00

`endif

/* File: ues_pkg.sv */
// Purpose: Types shared by the host endpoint schedule block
// Assumes: ues_consts.svh supplies the endpoint count
// Notes:   Direction index 0 is transmit, 1 is receive
`include "ues_consts.svh"

package ues_pkg;

   localparam int NEP = `UES_NEP;

   typedef struct packed {
      logic [1:0] proto;
      logic [3:0] target;
   } ues_type_t;

   typedef logic [1:0][NEP-1:0] ues_dir_vec_t;

   typedef ues_type_t [1:0][NEP-1:0] ues_type_arr_t;

   typedef enum logic [1:0] {
      CH_IDLE = 2'b01,
      CH_RESP = 2'b10
   } ues_chan_t;

   typedef enum logic [7:0] {
      RS_NONE    = 8'b0000_0001,
      RS_COUNT   = 8'b0000_0010,
      RS_TX_TYPE = 8'b0000_0100,
      RS_TX_IVL  = 8'b0000_1000,
      RS_RX_TYPE = 8'b0001_0000,
      RS_RX_IVL  = 8'b0010_0000,
      RS_EP_SEL  = 8'b0100_0000,
      RS_IRQ     = 8'b1000_0000
   } ues_regsel_t;

   typedef struct packed {
      ues_chan_t                    wst;
      ues_chan_t                    rst;
      logic                         aw_held;
      logic                         w_held;
      logic [31:0]                  awaddr;
      logic [31:0]                  wdata;
      logic                         wlane0;
      logic                         awready;
      logic                         wready;
      logic                         arready;
      logic                         bvalid;
      logic                         rvalid;
      logic [1:0]                   bresp;
      logic [1:0]                   rresp;
      logic [31:0]                  rdata;
      logic [3:0]                   ep_sel;
      logic [12:0]                  rx_count;
      logic [1:0][NEP-1:0][7:0]     ivl;
      ues_type_arr_t                typ;
      logic [1:0][NEP-1:0][15:0]    cnt;
      ues_dir_vec_t                 nak_on;
      ues_dir_vec_t                 due;
      ues_dir_vec_t                 flag;
      ues_dir_vec_t                 mask;
      logic                         irq;
   } ues_state_t;

endpackage

/* File: ues_sched.sv */
// Purpose: Host endpoint type, interval, NAK limit and receive byte count
// Assumes: AXI4-Lite slave on aclk; USB side pulses are one aclk wide
// Notes:   Frame counters advance on sof_tick only while in host mode
`timescale 1ns/10ps
`include "ues_consts.svh"

module ues_sched (
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic [31:0]           s_axi_awaddr,
   input  wire logic [2:0]            s_axi_awprot,
   input  wire logic                  s_axi_awvalid,
   output logic                       s_axi_awready,
   input  wire logic [31:0]           s_axi_wdata,
   input  wire logic [3:0]            s_axi_wstrb,
   input  wire logic                  s_axi_wvalid,
   output logic                       s_axi_wready,
   output logic [1:0]                 s_axi_bresp,
   output logic                       s_axi_bvalid,
   input  wire logic                  s_axi_bready,
   input  wire logic [31:0]           s_axi_araddr,
   input  wire logic [2:0]            s_axi_arprot,
   input  wire logic                  s_axi_arvalid,
   output logic                       s_axi_arready,
   output logic [31:0]                s_axi_rdata,
   output logic [1:0]                 s_axi_rresp,
   output logic                       s_axi_rvalid,
   input  wire logic                  s_axi_rready,
   input  wire logic                  host_mode,
   input  wire logic                  high_speed,
   input  wire logic                  sof_tick,
   input  wire ues_pkg::ues_dir_vec_t nak_seen,
   input  wire ues_pkg::ues_dir_vec_t ack_seen,
   input  wire logic                  rx_packet_ready,
   input  wire logic                  rx_count_load,
   input  wire logic [12:0]           rx_count_value,
   input  wire logic                  rx_unload,
   input  wire logic [2:0]            rx_unload_bytes,
   output ues_pkg::ues_dir_vec_t      poll_due,
   output ues_pkg::ues_dir_vec_t      ep_halted,
   output ues_pkg::ues_type_arr_t     ep_type,
   output logic                       irq
);

   localparam int NEP = ues_pkg::NEP;

   ues_pkg::ues_state_t st_reg;
   ues_pkg::ues_state_t st_next;

   // Byte address of a register index
   function automatic logic [31:0] addr_of(input logic [31:0] idx);
      addr_of = {idx[29:0], 2'h0};
   endfunction

   function automatic ues_pkg::ues_regsel_t decode(input logic [31:0] a);
      case (a)
         addr_of(`UES_IDX_RX_COUNT): decode = ues_pkg::RS_COUNT;
         addr_of(`UES_IDX_TX_TYPE):  decode = ues_pkg::RS_TX_TYPE;
         addr_of(`UES_IDX_TX_IVL):   decode = ues_pkg::RS_TX_IVL;
         addr_of(`UES_IDX_RX_TYPE):  decode = ues_pkg::RS_RX_TYPE;
         addr_of(`UES_IDX_RX_IVL):   decode = ues_pkg::RS_RX_IVL;
         addr_of(`UES_IDX_EP_SEL):   decode = ues_pkg::RS_EP_SEL;
         addr_of(`UES_IDX_IRQ_STAT): decode = ues_pkg::RS_IRQ;
         addr_of(`UES_IDX_IRQ_MASK): decode = ues_pkg::RS_IRQ;
         default:                    decode = ues_pkg::RS_NONE;
      endcase
   endfunction

   // Frame period for a type and interval; zero means no scheduling
   function automatic logic [15:0] period_of(input logic [1:0] proto,
                                             input logic [7:0] m,
                                             input logic       hs);
      logic [7:0] e;
      e = (m > `UES_EXP_MAX) ? `UES_EXP_MAX : m;
      period_of = 16'h0000;
      case (proto)
         `UES_PROTO_INTR: begin
            if (!hs) begin
               period_of = {8'h00, m};
            end else if (m != 8'h00) begin
               period_of = 16'h0001 << (e - 8'h01);
            end
         end
         `UES_PROTO_ISO: begin
            if (m != 8'h00) begin
               period_of = 16'h0001 << (e - 8'h01);
            end
         end
         `UES_PROTO_BULK: begin
            if (m >= `UES_BULK_MIN) begin
               period_of = 16'h0001 << (e - 8'h01);
            end
         end
         default: period_of = 16'h0000;
      endcase
   endfunction

   logic                 ep_ok;
   ues_pkg::ues_regsel_t wsel;
   ues_pkg::ues_regsel_t rsel;
   logic [15:0]          per;
   logic [12:0]          dec;
   ues_pkg::ues_dir_vec_t clr;

   always_comb begin
      st_next = st_reg;
      ep_ok   = (st_reg.ep_sel != 4'h0) && (st_reg.ep_sel < 4'(NEP));
      wsel    = decode(st_reg.awaddr);
      rsel    = decode(s_axi_araddr);
      per     = 16'h0000;
      dec     = 13'(rx_unload_bytes);
      clr     = '0;

      // Write address and data, taken in either order
      if (s_axi_awvalid && st_reg.awready) begin
         st_next.awaddr  = s_axi_awaddr;
         st_next.aw_held = 1'b1;
      end
      if (s_axi_wvalid && st_reg.wready) begin
         st_next.wdata   = s_axi_wdata;
         st_next.wlane0  = s_axi_wstrb[0];
         st_next.w_held  = 1'b1;
      end

      case (st_reg.wst)
         ues_pkg::CH_IDLE: begin
            if (st_reg.aw_held && st_reg.w_held) begin
               st_next.aw_held = 1'b0;
               st_next.w_held  = 1'b0;
               st_next.bvalid  = 1'b1;
               st_next.bresp   = `UES_RESP_OKAY;
               st_next.wst     = ues_pkg::CH_RESP;
               case (wsel)
                  ues_pkg::RS_NONE: st_next.bresp = `UES_RESP_SLVERR;
                  ues_pkg::RS_EP_SEL: begin
                     if (st_reg.wlane0) begin
                        st_next.ep_sel = st_reg.wdata[3:0];
                     end
                  end
                  ues_pkg::RS_IRQ: begin
                     if (st_reg.wlane0 && st_reg.awaddr == addr_of(`UES_IDX_IRQ_STAT)) begin
                        clr = ues_pkg::ues_dir_vec_t'(st_reg.wdata[2*NEP-1:0]);
                     end else if (st_reg.wlane0) begin
                        st_next.mask = ues_pkg::ues_dir_vec_t'(st_reg.wdata[2*NEP-1:0]);
                     end
                  end
                  default: begin
                     // Type and interval writes land in the selected slot only
                     for (int e = 1; e < NEP; e++) begin
                        if (ep_ok && st_reg.wlane0 && st_reg.ep_sel == 4'(e)) begin
                           if (wsel == ues_pkg::RS_TX_TYPE) begin
                              st_next.typ[0][e] = st_reg.wdata[5:0];
                           end
                           if (wsel == ues_pkg::RS_RX_TYPE) begin
                              st_next.typ[1][e] = st_reg.wdata[5:0];
                           end
                           if (wsel == ues_pkg::RS_TX_IVL) begin
                              st_next.ivl[0][e] = st_reg.wdata[7:0];
                           end
                           if (wsel == ues_pkg::RS_RX_IVL) begin
                              st_next.ivl[1][e] = st_reg.wdata[7:0];
                           end
                        end
                     end
                  end
               endcase
            end
         end
         ues_pkg::CH_RESP: begin
            if (s_axi_bready) begin
               st_next.bvalid = 1'b0;
               st_next.wst    = ues_pkg::CH_IDLE;
            end
         end
         default: st_next.wst = ues_pkg::CH_IDLE;
      endcase

      // Read channel
      case (st_reg.rst)
         ues_pkg::CH_IDLE: begin
            if (s_axi_arvalid && st_reg.arready) begin
               st_next.rvalid = 1'b1;
               st_next.rresp  = `UES_RESP_OKAY;
               st_next.rdata  = 32'h0000_0000;
               st_next.rst    = ues_pkg::CH_RESP;
               case (rsel)
                  ues_pkg::RS_NONE:  st_next.rresp = `UES_RESP_SLVERR;
                  ues_pkg::RS_COUNT: begin
                     if (rx_packet_ready) begin
                        st_next.rdata = {19'h0_0000, st_reg.rx_count};
                     end
                  end
                  ues_pkg::RS_EP_SEL: st_next.rdata = {28'h000_0000, st_reg.ep_sel};
                  ues_pkg::RS_IRQ: begin
                     if (s_axi_araddr == addr_of(`UES_IDX_IRQ_STAT)) begin
                        st_next.rdata = 32'(st_reg.flag);
                     end else begin
                        st_next.rdata = 32'(st_reg.mask);
                     end
                  end
                  default: begin
                     for (int e = 1; e < NEP; e++) begin
                        if (ep_ok && st_reg.ep_sel == 4'(e)) begin
                           if (rsel == ues_pkg::RS_TX_TYPE) begin
                              st_next.rdata = 32'(st_reg.typ[0][e]);
                           end
                           if (rsel == ues_pkg::RS_RX_TYPE) begin
                              st_next.rdata = 32'(st_reg.typ[1][e]);
                           end
                           if (rsel == ues_pkg::RS_TX_IVL) begin
                              st_next.rdata = 32'(st_reg.ivl[0][e]);
                           end
                           if (rsel == ues_pkg::RS_RX_IVL) begin
                              st_next.rdata = 32'(st_reg.ivl[1][e]);
                           end
                        end
                     end
                  end
               endcase
            end
         end
         ues_pkg::CH_RESP: begin
            if (s_axi_rready) begin
               st_next.rvalid = 1'b0;
               st_next.rst    = ues_pkg::CH_IDLE;
            end
         end
         default: st_next.rst = ues_pkg::CH_IDLE;
      endcase

      st_next.awready = !st_next.aw_held && st_next.wst == ues_pkg::CH_IDLE;
      st_next.wready  = !st_next.w_held && st_next.wst == ues_pkg::CH_IDLE;
      st_next.arready = st_next.rst == ues_pkg::CH_IDLE;

      // Receive byte count: load wins over unload, unload saturates at zero
      if (rx_count_load) begin
         st_next.rx_count = rx_count_value;
      end else if (rx_unload) begin
         st_next.rx_count = (st_reg.rx_count > dec) ?
                            st_reg.rx_count - dec : `UES_RST_COUNT;
      end

      // Per endpoint frame counters
      st_next.due = '0;
      for (int d = 0; d < 2; d++) begin
         for (int e = 0; e < NEP; e++) begin
            per = period_of(st_reg.typ[d][e].proto, st_reg.ivl[d][e], high_speed);
            if (!host_mode || e == 0 || per == 16'h0000) begin
               st_next.cnt[d][e]    = 16'h0000;
               st_next.nak_on[d][e] = 1'b0;
            end else if (st_reg.typ[d][e].proto == `UES_PROTO_BULK) begin
               if (ack_seen[d][e]) begin
                  st_next.cnt[d][e]    = 16'h0000;
                  st_next.nak_on[d][e] = 1'b0;
               end else begin
                  if (nak_seen[d][e]) begin
                     st_next.nak_on[d][e] = 1'b1;
                  end
                  if (sof_tick && st_reg.nak_on[d][e] && !st_reg.flag[d][e]) begin
                     if (st_reg.cnt[d][e] >= per - 16'h0001) begin
                        st_next.cnt[d][e]  = 16'h0000;
                        st_next.flag[d][e] = 1'b1;
                     end else begin
                        st_next.cnt[d][e] = st_reg.cnt[d][e] + 16'h0001;
                     end
                  end
               end
            end else if (sof_tick) begin
               if (st_reg.cnt[d][e] >= per - 16'h0001) begin
                  st_next.cnt[d][e] = 16'h0000;
                  st_next.due[d][e] = 1'b1;
               end else begin
                  st_next.cnt[d][e] = st_reg.cnt[d][e] + 16'h0001;
               end
            end
         end
      end

      // Sticky flags: a set in the same cycle beats the clear
      st_next.flag = (st_reg.flag & ~clr) | (st_next.flag & ~st_reg.flag);
      st_next.irq  = |(st_next.flag & st_next.mask);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg     <= '0;
         st_reg.wst <= ues_pkg::CH_IDLE;
         st_reg.rst <= ues_pkg::CH_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   assign s_axi_awready = st_reg.awready;
   assign s_axi_wready  = st_reg.wready;
   assign s_axi_bvalid  = st_reg.bvalid;
   assign s_axi_bresp   = st_reg.bresp;
   assign s_axi_arready = st_reg.arready;
   assign s_axi_rvalid  = st_reg.rvalid;
   assign s_axi_rresp   = st_reg.rresp;
   assign s_axi_rdata   = st_reg.rdata;
   assign poll_due      = st_reg.due;
   assign ep_halted     = st_reg.flag;
   assign ep_type       = st_reg.typ;
   assign irq           = st_reg.irq;

endmodule

/* File: ues_sched_bench.sv */
// Purpose: Self-checking bench for ues_sched
// Assumes: 250 MHz aclk, frame tick every 8 cycles
// Notes:   Byte address is four times the register index
`timescale 1ns/10ps
`include "ues_consts.svh"
module ues_sched_bench;
   logic                   aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic [31:0]            awaddr, wdata, araddr, rdata;
   logic                   host_mode, high_speed, pkt_rdy, cnt_load, unload;
   logic [12:0]            cnt_val;
   logic [2:0]             unload_n;
   logic                   awready, wready, bvalid, arready, rvalid, irq, sof;
   logic [1:0]             bresp, rresp;
   ues_pkg::ues_dir_vec_t  poll_due, halted, nak_seen, ack_seen, nak_mode, kick;
   ues_pkg::ues_type_arr_t ep_type;
   int                     fails, checks, cyc;
   localparam logic [1:0]  OK = `UES_RESP_OKAY;
   ues_sched uut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .host_mode(host_mode),
      .high_speed(high_speed), .sof_tick(sof), .nak_seen(nak_seen), .ack_seen(ack_seen),
      .rx_packet_ready(pkt_rdy), .rx_count_load(cnt_load), .rx_count_value(cnt_val),
      .rx_unload(unload), .rx_unload_bytes(unload_n), .poll_due(poll_due),
      .ep_halted(halted), .ep_type(ep_type), .irq(irq));
   ues_usb_dev dev (
      .aclk(aclk), .aresetn(aresetn), .poll_due(poll_due), .nak_mode(nak_mode),
      .kick(kick), .sof_tick(sof), .nak_seen(nak_seen), .ack_seen(ack_seen));
   task automatic end_sim;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks++;
      if (g !== e) begin
         fails++;
         $display("BAD %0t got %h want %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [31:0] i, input logic [31:0] d, input logic [1:0] e);
      int  n;
      logic aw, w;
      n = 0;
      aw = 1'b1;
      w = 1'b1;
      @(posedge aclk);
      awaddr  <= {i[29:0], 2'b00};
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
         if (aw && awready === 1'b1) begin
            aw = 1'b0;
            awvalid <= 1'b0;
         end
         if (w && wready === 1'b1) begin
            w = 1'b0;
            wvalid <= 1'b0;
         end
      end while ((aw || w || bvalid !== 1'b1) && n < 200);
      bready <= 1'b0;
      chk(32'(bvalid), 32'h0000_0001);
      chk(32'(bresp), 32'(e));
   endtask
   task automatic rdc(input logic [31:0] i, input logic [31:0] e, input logic [1:0] r);
      int n;
      n = 0;
      @(posedge aclk);
      araddr  <= {i[29:0], 2'b00};
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
      end while (arready !== 1'b1 && n < 200);
      arvalid <= 1'b0;
      rready  <= 1'b1;
      do begin
         @(posedge aclk);
         n++;
      end while (rvalid !== 1'b1 && n < 400);
      rready <= 1'b0;
      chk(32'(rvalid), 32'h0000_0001);
      chk(rdata, e);
      chk(32'(rresp), 32'(r));
   endtask
   task automatic cfg(input int d, input int e, input logic [1:0] p, input logic [7:0] m);
      wr(`UES_IDX_EP_SEL, 32'(e), OK);
      wr(d ? `UES_IDX_RX_TYPE : `UES_IDX_TX_TYPE, {26'h0, p, 4'h5}, OK);
      wr(d ? `UES_IDX_RX_IVL : `UES_IDX_TX_IVL, {24'h0, m}, OK);
   endtask
   // Frame ticks between two polls of one endpoint
   task automatic period(input int d, input int e, input int exp);
      int n;
      n = 0;
      do @(posedge aclk); while (poll_due[d][e] !== 1'b1 && n++ < 5000);
      n = 0;
      do begin
         @(posedge aclk);
         if (sof === 1'b1)
            n++;
      end while (poll_due[d][e] !== 1'b1 && n < 300);
      chk(32'(n), 32'(exp));
   endtask
   task automatic t_reset;
      rdc(`UES_IDX_RX_COUNT, 32'h0000_0000, OK);
      wr(`UES_IDX_EP_SEL, 32'h0000_0001, OK);
      rdc(`UES_IDX_TX_IVL, 32'h0000_0000, OK);
      rdc(`UES_IDX_RX_IVL, 32'h0000_0000, OK);
      rdc(`UES_IDX_TX_TYPE, 32'h0000_0000, OK);
      rdc(32'h1344_0040, 32'h0000_0000, `UES_RESP_SLVERR);
      wr(32'h1344_0040, 32'h0000_0001, `UES_RESP_SLVERR);
   endtask
   task automatic t_regs;
      for (int p = 1; p < 4; p++) begin
         wr(`UES_IDX_TX_TYPE, 32'(p * 16 + 5), OK);
         chk(32'(ep_type[0][1]), 32'(p * 16 + 5));
      end
      wr(`UES_IDX_TX_TYPE, 32'hFFFF_FFFF, OK);
      rdc(`UES_IDX_TX_TYPE, 32'h0000_003F, OK);
      wr(`UES_IDX_TX_IVL, 32'hFFFF_FFFF, OK);
      wr(`UES_IDX_EP_SEL, 32'h0000_0002, OK);
      wr(`UES_IDX_RX_IVL, 32'hFFFF_FF22, OK);
      rdc(`UES_IDX_RX_IVL, 32'h0000_0022, OK);
      wr(`UES_IDX_EP_SEL, 32'h0000_0000, OK);
      wr(`UES_IDX_TX_TYPE, 32'h0000_0025, OK);
      chk(32'(ep_type[0][0]), 32'h0000_0000);
      wr(`UES_IDX_EP_SEL, 32'h0000_0001, OK);
      rdc(`UES_IDX_TX_IVL, 32'h0000_00FF, OK);
   endtask
   task automatic t_count;
      @(posedge aclk);
      cnt_val  <= 13'h1FFF;
      cnt_load <= 1'b1;
      pkt_rdy  <= 1'b1;
      @(posedge aclk);
      cnt_load <= 1'b0;
      wr(`UES_IDX_RX_COUNT, 32'h0000_0000, OK);
      rdc(`UES_IDX_RX_COUNT, 32'h0000_1FFF, OK);
      unload   <= 1'b1;
      unload_n <= 3'h7;
      @(posedge aclk);
      unload   <= 1'b0;
      rdc(`UES_IDX_RX_COUNT, 32'h0000_1FF8, OK);
      pkt_rdy  <= 1'b0;
      rdc(`UES_IDX_RX_COUNT, 32'h0000_0000, OK);
   endtask
   task automatic t_sched;
      int n;
      n = 0;
      cfg(1, 1, `UES_PROTO_INTR, 8'hFF);
      period(1, 1, 255);
      wr(`UES_IDX_RX_IVL, 32'h0000_0003, OK);
      high_speed <= 1'b1;
      period(1, 1, 4);
      cfg(0, 3, `UES_PROTO_ISO, 8'h02);
      period(0, 3, 2);
      // Illegal protocol code stops the polls of that slot
      wr(`UES_IDX_TX_TYPE, 32'h0000_0005, OK);
      repeat (40) begin
         @(posedge aclk);
         if (poll_due[0][3] === 1'b1)
            n++;
      end
      chk(32'(n), 32'h0000_0000);
      host_mode <= 1'b0;
      @(posedge aclk);
      repeat (40) begin
         @(posedge aclk);
         if (poll_due !== '0)
            n++;
      end
      chk(32'(n), 32'h0000_0000);
      chk(32'(halted), 32'h0000_0000);
      host_mode <= 1'b1;
   endtask
   task automatic t_bulk;
      int n;
      n = 0;
      cfg(1, 2, `UES_PROTO_BULK, 8'h03);
      nak_mode[1][2] <= 1'b1;
      do @(posedge aclk); while (sof !== 1'b1);
      kick[1][2] <= 1'b1;
      @(posedge aclk);
      kick <= '0;
      do begin
         @(posedge aclk);
         if (sof === 1'b1)
            n++;
      end while (halted[1][2] !== 1'b1 && n < 40);
      chk(32'(n), 32'h0000_0004);
      rdc(`UES_IDX_IRQ_STAT, 32'h0000_0040, OK);
      chk(32'(irq), 32'h0000_0000);
      wr(`UES_IDX_IRQ_MASK, 32'h0000_0040, OK);
      rdc(`UES_IDX_IRQ_MASK, 32'h0000_0040, OK);
      chk(32'(irq), 32'h0000_0001);
      wr(`UES_IDX_IRQ_STAT, 32'h0000_0040, OK);
      rdc(`UES_IDX_IRQ_STAT, 32'h0000_0000, OK);
      chk(32'(irq), 32'h0000_0000);
      for (int m = 0; m < 2; m++) begin
         wr(`UES_IDX_RX_IVL, 32'(m), OK);
         kick[1][2] <= 1'b1;
         @(posedge aclk);
         kick <= '0;
         repeat (120) @(posedge aclk);
         chk(32'(halted[1][2]), 32'h0000_0000);
      end
   endtask
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 30000) begin
         fails++;
         end_sim();
      end
   end
   initial begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, wdata, araddr, cnt_val, unload_n} = '0;
      {high_speed, pkt_rdy, cnt_load, unload, nak_mode, kick} = '0;
      host_mode = 1'b1;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_regs();
      t_count();
      t_sched();
      t_bulk();
      end_sim();
   end
endmodule

/* File: ues_sched_checker.sv */
// Purpose: Port assertions for ues_sched
// Assumes: One aclk domain, aresetn synchronous active low
// Notes:   Bound to every ues_sched below the module
`timescale 1ns/10ps
`include "ues_consts.svh"
module ues_sched_checker (
   input wire logic                  aclk,
   input wire logic                  aresetn,
   input wire logic                  s_axi_awvalid,
   input wire logic                  s_axi_awready,
   input wire logic                  s_axi_wvalid,
   input wire logic                  s_axi_wready,
   input wire logic                  s_axi_bvalid,
   input wire logic                  s_axi_arvalid,
   input wire logic                  s_axi_arready,
   input wire logic [31:0]           s_axi_rdata,
   input wire logic [1:0]            s_axi_rresp,
   input wire logic                  s_axi_rvalid,
   input wire logic                  host_mode,
   input wire logic                  sof_tick,
   input wire ues_pkg::ues_dir_vec_t poll_due,
   input wire ues_pkg::ues_dir_vec_t ep_halted,
   input wire logic                  irq
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write answer late");
   AST_WR_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
      && !s_axi_arready) else $error("read answer late");
   AST_RD_ERR: assert property (s_axi_rvalid && s_axi_rresp == `UES_RESP_SLVERR
      |-> s_axi_rdata == 32'h0000_0000) else $error("error read carries data");
   AST_POLL_SOF: assert property (poll_due != '0 |-> $past(sof_tick)
      && $past(host_mode)) else $error("poll without frame tick");
   AST_NO_HOST: assert property (!host_mode |=> poll_due == '0)
      else $error("poll outside host mode");
   AST_EP0_IDLE: assert property (poll_due[0][0] == 1'b0
      && poll_due[1][0] == 1'b0 && ep_halted[0][0] == 1'b0 && ep_halted[1][0] == 1'b0)
      else $error("endpoint 0 scheduled");
   AST_HALT_SOF: assert property ((ep_halted & ~$past(ep_halted)) != '0
      |-> $past(sof_tick) && $past(host_mode)) else $error("halt without frame tick");
   AST_HALT_HOLD: assert property (($past(ep_halted) & ~ep_halted) != '0
      |-> s_axi_bvalid) else $error("halt cleared without write");
   AST_IRQ_SRC: assert property (irq |-> ep_halted != '0)
      else $error("interrupt without status");
endmodule

bind ues_sched ues_sched_checker chk_i (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .host_mode(host_mode), .sof_tick(sof_tick),
   .poll_due(poll_due), .ep_halted(ep_halted), .irq(irq));

/* File: ues_usb_dev.sv */
// Purpose: Peripheral side model, frame ticks and handshakes
// Assumes: One aclk domain, aresetn synchronous active low
// Notes:   nak_mode picks NAK or ACK per endpoint
`timescale 1ns/10ps
module ues_usb_dev #(
   parameter int SOF_GAP = 8
) (
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire ues_pkg::ues_dir_vec_t poll_due,
   input  wire ues_pkg::ues_dir_vec_t nak_mode,
   input  wire ues_pkg::ues_dir_vec_t kick,
   output logic                       sof_tick,
   output ues_pkg::ues_dir_vec_t      nak_seen,
   output ues_pkg::ues_dir_vec_t      ack_seen
);
   int cnt;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt      <= 0;
         sof_tick <= 1'b0;
         nak_seen <= '0;
         ack_seen <= '0;
      end else begin
         cnt      <= (cnt == SOF_GAP - 1) ? 0 : cnt + 1;
         sof_tick <= (cnt == SOF_GAP - 1);
         // One handshake per poll or attempt
         nak_seen <= (poll_due | kick) & nak_mode;
         ack_seen <= (poll_due | kick) & ~nak_mode;
      end
   end
endmodule
